// [vom_mux_i2c_slave.sv]
// two-wire slave with stored output codes and output multiplexer
`timescale 1ns/10ps
`default_nettype none
module vom_mux_i2c_slave
#(
  parameter int NV_WAIT = vom_pkg::NV_CYCLES
)
(
  input wire logic mclk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic scl, // serial clock from master, link clock
  input wire logic sda_i, // serial data level
  output logic sda_o, // serial data drive value
  output logic sda_oe, // serial data pull-low enable
  input wire logic [4:0] in_port, // parallel input pins
  input wire vom_pkg::vom_ctrl_t ctrl, // static control pins
  output logic [4:0] out_code, // multiplexed output port
  output logic unmuxed_out // non-multiplexed latched output
);

  // five-bit code field {b5,b3..b0} for the output port
  function automatic logic [4:0] pick_code(input vom_pkg::vom_code_t c);
    pick_code = {c.b5, c.lo};
  endfunction

  function automatic logic addr_hit(input logic [6:0] a, input logic choice);
    addr_hit = choice ? (a == vom_pkg::ADDR_CHOICE_HIGH) : (a == vom_pkg::ADDR_CHOICE_LOW);
  endfunction

  // ---------------- pin synchronisers ----------------
  logic [1:0] scl_sy;
  logic [1:0] sda_sy;
  logic scl_d;
  logic sda_d;
  logic [4:0] pin_sy0;
  logic [4:0] pin_s;
  logic [3:0] ctl_sy0;
  vom_pkg::vom_ctrl_t ctl_s;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_sy <= 2'h3;
      sda_sy <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_sy <= {scl_sy[0], scl};
      sda_sy <= {sda_sy[0], sda_i};
      scl_d <= scl_sy[1];
      sda_d <= sda_sy[1];
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_sy0 <= 5'h00;
      pin_s <= 5'h00;
      ctl_sy0 <= 4'h0;
      ctl_s <= '0;
    end
    else
    begin
      pin_sy0 <= in_port;
      pin_s <= pin_sy0;
      ctl_sy0 <= ctrl;
      ctl_s <= ctl_sy0;
    end
  end

  // oversampling at 40 MHz leaves dozens of samples per bit even at the fast rate
  logic start_det;
  logic stop_det;
  assign start_det = scl_sy[1] & scl_d & sda_d & ~sda_sy[1];
  assign stop_det = scl_sy[1] & scl_d & ~sda_d & sda_sy[1];

  // ---------------- frame tracking and link reset ----------------
  // the link logic is held in reset between frames and briefly at each start,
  // released only once the clock is low so no edge meets the release
  logic in_frame;
  logic link_hold;
  logic cap_arm;
  logic link_rst_n;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      in_frame <= 1'b0;
      link_hold <= 1'b1;
    end
    else if (start_det)
    begin
      in_frame <= 1'b1;
      link_hold <= 1'b1;
    end
    else if (stop_det)
    begin
      in_frame <= 1'b0;
      link_hold <= 1'b1;
    end
    else if (in_frame && !scl_sy[1])
    begin
      link_hold <= 1'b0;
    end
  end

  assign link_rst_n = resetn & ~link_hold;

  // pin capture on the first clock rise after each start
  logic [4:0] capture;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cap_arm <= 1'b0;
      capture <= vom_pkg::CAPTURE_RESET;
    end
    else if (start_det)
    begin
      cap_arm <= 1'b1;
    end
    else if (cap_arm && scl_sy[1] && !scl_d)
    begin
      cap_arm <= 1'b0;
      capture <= pin_s;
    end
  end

  // ---------------- stored codes and selection ----------------
  logic [5:0] code_a;
  logic [5:0] code_b;
  logic [1:0] sel_cur;
  logic [1:0] sel_pend;
  logic sel_pend_v;
  logic [5:0] pend_data;
  logic pend_to_b;
  logic nv_busy;
  logic [vom_pkg::NV_CNT_W-1:0] nv_cnt;
  logic [7:0] wr_byte;
  logic wr_tgl;
  logic [2:0] wt_sy;
  logic wr_evt;
  logic wr_ok;
  vom_pkg::vom_code_t wr_code;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      wt_sy <= 3'h0;
    else
      wt_sy <= {wt_sy[1:0], wr_tgl};
  end

  assign wr_evt = wt_sy[2] ^ wt_sy[1];
  // the byte stays put in the link domain until the next one, long after this edge
  assign wr_code = wr_byte;
  assign wr_ok = wr_evt & ~ctl_s.write_lock;

  // pending selection is applied only at a stop
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sel_cur <= vom_pkg::SEL_IN;
      sel_pend <= vom_pkg::SEL_IN;
      sel_pend_v <= 1'b0;
    end
    else
    begin
      if (stop_det && sel_pend_v)
        sel_cur <= sel_pend;
      if (wr_ok && wr_code.sel != vom_pkg::SEL_BAD)
      begin
        sel_pend <= wr_code.sel;
        sel_pend_v <= 1'b1;
      end
      else if (stop_det)
        sel_pend_v <= 1'b0;
    end
  end

  // slow non-volatile update; a newer write restarts the wait
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      nv_busy <= 1'b0;
      nv_cnt <= '0;
      pend_data <= vom_pkg::CODE_DATA_RESET;
      pend_to_b <= 1'b0;
    end
    else if (wr_ok && (wr_code.sel == vom_pkg::SEL_A || wr_code.sel == vom_pkg::SEL_B))
    begin
      nv_busy <= 1'b1;
      nv_cnt <= vom_pkg::NV_CNT_W'(NV_WAIT - 1);
      pend_data <= wr_byte[5:0];
      pend_to_b <= (wr_code.sel == vom_pkg::SEL_B);
    end
    else if (nv_busy)
    begin
      if (nv_cnt == '0)
        nv_busy <= 1'b0;
      else
        nv_cnt <= nv_cnt - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      code_a <= vom_pkg::CODE_DATA_RESET;
      code_b <= vom_pkg::CODE_DATA_RESET;
    end
    else if (nv_busy && nv_cnt == '0)
    begin
      if (pend_to_b)
        code_b <= pend_data;
      else
        code_a <= pend_data;
    end
  end

  // ---------------- output multiplexer ----------------
  vom_pkg::vom_code_t view_a;
  vom_pkg::vom_code_t view_b;
  logic nm_latch;
  logic next_latch;
  logic [4:0] next_code;

  assign view_a = {sel_cur, code_a};
  assign view_b = {sel_cur, code_b};

  always_comb
  begin
    next_code = pin_s;
    next_latch = nm_latch;
    if (!ctl_s.path_select_input)
    begin
      unique case (sel_cur)
        vom_pkg::SEL_A:
        begin
          next_code = pick_code(view_a);
          next_latch = view_a.nm;
        end
        vom_pkg::SEL_B:
        begin
          next_code = pick_code(view_b);
          next_latch = view_b.nm;
        end
        vom_pkg::SEL_IN: next_code = pin_s;
        vom_pkg::SEL_BAD: next_code = pin_s;
      endcase
      if (!ctl_s.force_low_input_n)
        next_latch = 1'b0; // the latch follows the zero it shows
    end
  end

  // latch follows only while path select is low, so it keeps the value shown at the rise
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      nm_latch <= 1'b0;
    else if (!ctl_s.path_select_input)
      nm_latch <= next_latch;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_code <= 5'h00;
      unmuxed_out <= 1'b0;
    end
    else if (!ctl_s.force_low_input_n)
    begin
      out_code <= 5'h00;
      unmuxed_out <= 1'b0;
    end
    else
    begin
      out_code <= ctl_s.path_select_input ? pin_s : next_code;
      unmuxed_out <= ctl_s.path_select_input ? nm_latch : next_latch;
    end
  end

  // ---------------- read view, frozen while a frame runs ----------------
  vom_pkg::vom_code_t rd_a;
  vom_pkg::vom_code_t rd_b;
  logic addr_choice_v;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_a <= {vom_pkg::SEL_IN, vom_pkg::CODE_DATA_RESET};
      rd_b <= {vom_pkg::SEL_IN, vom_pkg::CODE_DATA_RESET};
      addr_choice_v <= 1'b0;
    end
    else if (!in_frame)
    begin
      rd_a <= view_a;
      rd_b <= view_b;
      addr_choice_v <= ctl_s.slave_addr_choice;
    end
  end

  // ---------------- link domain, clocked by the master's clock ----------------
  vom_pkg::vom_link_state_t st;
  logic [3:0] cnt;
  logic [6:0] shreg;
  logic rw;
  logic [1:0] rd_idx;
  logic [7:0] rd_byte;

  always_ff @(posedge scl or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      st <= vom_pkg::ST_ADDR;
      cnt <= vom_pkg::BIT_FIRST;
      shreg <= 7'h00;
      rw <= 1'b0;
      rd_idx <= vom_pkg::IDX_CODE_A;
    end
    else if (cnt == vom_pkg::BIT_ACK)
    begin
      cnt <= vom_pkg::BIT_FIRST;
      unique case (st)
        vom_pkg::ST_ADDR: st <= rw ? vom_pkg::ST_RDATA : vom_pkg::ST_WDATA;
        vom_pkg::ST_RDATA:
        begin
          if (sda_i)
            st <= vom_pkg::ST_IGNORE; // master declined another byte
          else if (rd_idx == vom_pkg::IDX_CAPTURE)
            rd_idx <= vom_pkg::IDX_CODE_A;
          else
            rd_idx <= rd_idx + 1'b1;
        end
        vom_pkg::ST_WDATA: st <= vom_pkg::ST_WDATA;
        vom_pkg::ST_IGNORE: st <= vom_pkg::ST_IGNORE;
      endcase
    end
    else
    begin
      cnt <= cnt + 1'b1;
      shreg <= {shreg[5:0], sda_i};
      if (cnt == vom_pkg::BIT_LAST && st == vom_pkg::ST_ADDR)
      begin
        if (addr_hit(shreg, addr_choice_v))
          rw <= sda_i;
        else
          st <= vom_pkg::ST_IGNORE;
      end
    end
  end

  // write bytes hand over by toggle; the capture register is never a target
  always_ff @(posedge scl or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_tgl <= 1'b0;
      wr_byte <= 8'h00;
    end
    else if (link_rst_n && st == vom_pkg::ST_WDATA && cnt == vom_pkg::BIT_LAST)
    begin
      wr_tgl <= ~wr_tgl;
      wr_byte <= {shreg, sda_i};
    end
  end

  always_comb
  begin
    unique case (rd_idx)
      vom_pkg::IDX_CODE_A: rd_byte = rd_a;
      vom_pkg::IDX_CODE_B: rd_byte = rd_b;
      default: rd_byte = {vom_pkg::CAPTURE_PAD, capture};
    endcase
  end

  // data line driven low on the falling clock; clock itself is only an input
  always_ff @(negedge scl or negedge link_rst_n)
  begin
    if (!link_rst_n)
      sda_oe <= 1'b0;
    else if (cnt == vom_pkg::BIT_ACK)
      sda_oe <= (st == vom_pkg::ST_ADDR) || (st == vom_pkg::ST_WDATA);
    else if (st == vom_pkg::ST_RDATA)
      sda_oe <= ~rd_byte[3'(vom_pkg::BIT_LAST - cnt)];
    else
      sda_oe <= 1'b0;
  end

  assign sda_o = 1'b0;

  // ---------------- checks ----------------
  // code field of register a as the output port would show it
  logic [4:0] pick_a;
  assign pick_a = pick_code(view_a);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence s_write_taken;
    wr_evt && !ctl_s.write_lock;
  endsequence

  sequence s_locked_write;
    wr_evt && ctl_s.write_lock;
  endsequence

  chk_force_zero: assert property (!ctl_s.force_low_input_n |=> out_code == 5'h00 && !unmuxed_out)
    else $error("outputs not forced low");

  chk_lock_blocks: assert property ((s_locked_write and !nv_busy) |=> !nv_busy [*2])
    else $error("locked write started an update");

  chk_path_inputs: assert property (ctl_s.force_low_input_n && ctl_s.path_select_input
    |=> out_code == $past(pin_s))
    else $error("inputs not routed with path select high");

  chk_stored_route: assert property (ctl_s.force_low_input_n && !ctl_s.path_select_input
    && sel_cur == vom_pkg::SEL_A |=> out_code == $past(pick_a))
    else $error("stored code a not routed");

  chk_latch_hold: assert property (ctl_s.path_select_input |=> $stable(nm_latch))
    else $error("unmuxed latch moved while path select high");

  chk_sel_at_stop: assert property (!stop_det |=> $stable(sel_cur))
    else $error("selection changed outside a stop");

  chk_nv_wait: assert property ((s_write_taken and wr_code.sel == vom_pkg::SEL_A)
    |=> (nv_busy && $stable(code_a)) [*8])
    else $error("stored code updated early");

  chk_read_still: assert property (!nv_busy |=> $stable(code_a) && $stable(code_b))
    else $error("stored codes changed without update");

  chk_sel_legal: assert property (sel_cur != vom_pkg::SEL_BAD)
    else $error("forbidden selection reached");

endmodule
`default_nettype wire

// [vom_pkg.sv]
// constants, field layouts and types for the output-code multiplexer with two-wire slave
package vom_pkg;

  localparam logic [1:0] SEL_A = 2'h0;
  localparam logic [1:0] SEL_B = 2'h1;
  localparam logic [1:0] SEL_IN = 2'h2;
  localparam logic [1:0] SEL_BAD = 2'h3;

  localparam logic [6:0] ADDR_CHOICE_HIGH = 7'h4e;
  localparam logic [6:0] ADDR_CHOICE_LOW = 7'h37;

  localparam logic [1:0] IDX_CODE_A = 2'h0;
  localparam logic [1:0] IDX_CODE_B = 2'h1;
  localparam logic [1:0] IDX_CAPTURE = 2'h2;

  localparam logic [2:0] CAPTURE_PAD = 3'h0;
  localparam logic [5:0] CODE_DATA_RESET = 6'h00;
  localparam logic [4:0] CAPTURE_RESET = 5'h00;

  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  localparam int NV_TIME_MS = 10;
  localparam int MCLK_HZ = 40000000;
  localparam int NV_CYCLES = NV_TIME_MS * (MCLK_HZ / 1000);
  localparam int NV_CNT_W = 20;

  // one stored output code byte as it appears on the bus
  typedef struct packed {
    logic [1:0] sel;
    logic b5;
    logic nm;
    logic [3:0] lo;
  } vom_code_t;

  // static control pins
  typedef struct packed {
    logic force_low_input_n;
    logic path_select_input;
    logic write_lock;
    logic slave_addr_choice;
  } vom_ctrl_t;

  typedef enum logic [3:0] {
    ST_ADDR = 4'h1,
    ST_WDATA = 4'h2,
    ST_RDATA = 4'h4,
    ST_IGNORE = 4'h8
  } vom_link_state_t;

endpackage

// [vom_i2c_master.sv]
// two-wire bus master model that drives the serial clock and the data line
`timescale 1ns/10ps
`default_nettype none
module vom_i2c_master
(
  output logic scl, // serial clock, idles high
  output logic sda_low, // high while the master pulls data low
  input wire logic sda_line // resolved level of the data line
);
  int qtr = 625; // quarter bit time in ns, fast rate by default
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // also serves as a repeated start when entered with the clock low
  // line changes land after the system clock edge they coincide with
  task automatic start();
    sda_low <= 1'b0;
    #qtr;
    scl <= 1'b1;
    #qtr;
    sda_low <= 1'b1;
    #qtr;
    scl <= 1'b0;
    #qtr;
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    #qtr;
    scl <= 1'b1;
    #qtr;
    sda_low <= 1'b0;
    #qtr;
  endtask
  // data only moves while the clock is low
  task automatic one_bit(input logic b, output logic r);
    sda_low <= ~b;
    #qtr;
    scl <= 1'b1;
    #qtr;
    r = sda_line;
    #qtr;
    scl <= 1'b0;
    #qtr;
  endtask
  // a released line reads what the slave drives; ack_in low asks for another byte
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
    output logic ack);
    for (int i = 7; i >= 0; i--)
      one_bit(d[i], q[i]);
    one_bit(ack_in, ack);
  endtask
endmodule
`default_nettype wire

// [vom_mux_i2c_slave_bench.sv]
// self-checking bench for the output-code multiplexer with two-wire slave
`timescale 1ns/10ps
`default_nettype none
module vom_mux_i2c_slave_bench;
  localparam int NV = 200;
  logic mclk;
  logic resetn;
  logic scl;
  logic m_low;
  logic sda;
  logic sda_o;
  logic sda_oe;
  logic [4:0] in_port;
  vom_pkg::vom_ctrl_t ctrl;
  logic [4:0] out_code;
  logic unmuxed_out;
  logic [7:0] q;
  logic ack;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  // open-drain data line, pulled up when nobody pulls it low
  assign sda = (m_low | sda_oe) ? 1'b0 : 1'b1;
  vom_mux_i2c_slave #(.NV_WAIT(NV)) i_vom_mux_i2c_slave (
    .mclk(mclk), .resetn(resetn), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .in_port(in_port), .ctrl(ctrl), .out_code(out_code), .unmuxed_out(unmuxed_out));
  vom_i2c_master i_vom_i2c_master (.scl(scl), .sda_low(m_low), .sda_line(sda));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic addr(input logic [6:0] a, input logic rd, input logic ea);
    i_vom_i2c_master.start();
    i_vom_i2c_master.xfer({a, rd}, 1'b1, q, ack);
    check("address ack", {7'h0, ack}, {7'h0, ea});
  endtask
  task automatic wr(input logic [7:0] d);
    addr(7'h4e, 1'b0, 1'b0);
    i_vom_i2c_master.xfer(d, 1'b1, q, ack);
    check("data ack", {7'h0, ack}, 8'h00);
  endtask
  task automatic wr_stop(input logic [7:0] d);
    wr(d);
    i_vom_i2c_master.stop();
    cyc(NV + 50);
  endtask
  // the pins move after the address byte, so a late capture shows up
  task automatic rd3(input logic [7:0] ea, input logic [7:0] eb);
    logic [7:0] ec;
    ec = {3'h0, in_port};
    addr(7'h4e, 1'b1, 1'b0);
    @(posedge mclk) in_port <= in_port ^ 5'h1f;
    i_vom_i2c_master.xfer(8'hff, 1'b0, q, ack);
    check("read a", q, ea);
    i_vom_i2c_master.xfer(8'hff, 1'b0, q, ack);
    check("read b", q, eb);
    i_vom_i2c_master.xfer(8'hff, 1'b1, q, ack);
    check("read capture", q, ec);
    i_vom_i2c_master.stop();
  endtask
  task automatic outs(input logic [4:0] ec, input logic en);
    cyc(8);
    check("out code", {3'h0, out_code}, {3'h0, ec});
    check("unmuxed out", {7'h0, unmuxed_out}, {7'h0, en});
  endtask
  task automatic t_power_up();
    outs(in_port, 1'b0);
    check("data drive value", {7'h0, sda_o}, 8'h00);
    i_vom_i2c_master.qtr = 2500;
    rd3(8'h80, 8'h80);
    i_vom_i2c_master.qtr = 625;
    outs(in_port, 1'b0);
  endtask
  task automatic t_store_codes();
    wr_stop(8'h3a);
    outs(5'h1a, 1'b1);
    wr(8'h05);
    outs(5'h1a, 1'b1);
    cyc(NV + 50);
    outs(5'h05, 1'b0);
    i_vom_i2c_master.stop();
    wr(8'h51);
    cyc(NV + 50);
    outs(5'h05, 1'b0);
    i_vom_i2c_master.stop();
    outs(5'h01, 1'b1);
    rd3(8'h45, 8'h51);
  endtask
  task automatic t_force_low();
    @(posedge mclk) ctrl.force_low_input_n <= 1'b0;
    outs(5'h00, 1'b0);
    @(posedge mclk) ctrl.force_low_input_n <= 1'b1;
    outs(5'h01, 1'b1);
  endtask
  task automatic t_lock();
    @(posedge mclk) ctrl.write_lock <= 1'b1;
    cyc(4);
    wr_stop(8'h3f);
    outs(5'h01, 1'b1);
    rd3(8'h45, 8'h51);
    @(posedge mclk) ctrl.write_lock <= 1'b0;
  endtask
  task automatic t_path_high();
    @(posedge mclk) ctrl.path_select_input <= 1'b1;
    outs(in_port, 1'b1);
    wr_stop(8'h40);
    outs(in_port, 1'b1);
    @(posedge mclk) in_port <= 5'h0c;
    outs(5'h0c, 1'b1);
    @(posedge mclk) ctrl.path_select_input <= 1'b0;
    outs(5'h00, 1'b0);
  endtask
  task automatic t_dest_codes();
    wr_stop(8'hff);
    rd3(8'h45, 8'h40);
    wr_stop(8'h80);
    outs(in_port, 1'b0);
    rd3(8'h85, 8'h80);
    addr(7'h4e, 1'b1, 1'b0);
    i_vom_i2c_master.xfer(8'hff, 1'b1, q, ack);
    check("read a only", q, 8'h85);
    i_vom_i2c_master.stop();
    cyc(8);
    check("data drive after a only", {7'h0, sda_oe}, 8'h00);
  endtask
  task automatic t_address();
    @(posedge mclk) ctrl.slave_addr_choice <= 1'b0;
    cyc(8);
    addr(7'h4e, 1'b0, 1'b1);
    i_vom_i2c_master.stop();
    addr(7'h37, 1'b0, 1'b0);
    i_vom_i2c_master.stop();
    addr(7'h00, 1'b0, 1'b1);
    i_vom_i2c_master.stop();
    @(posedge mclk) ctrl.slave_addr_choice <= 1'b1;
    cyc(8);
    addr(7'h37, 1'b0, 1'b1);
    i_vom_i2c_master.stop();
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  initial
  begin
    resetn = 1'b0;
    in_port = 5'h15;
    // force low off, path low, unlocked, address choice high
    ctrl = '{1'b1, 1'b0, 1'b0, 1'b1};
    cyc(4);
    resetn <= 1'b1;
    cyc(10);
    t_power_up();
    t_store_codes();
    t_force_low();
    t_lock();
    t_path_high();
    t_dest_codes();
    t_address();
    end_of_test();
  end
endmodule
`default_nettype wire
